// File: rtl/pmc_pkg.sv
// Purpose: Types shared by the pot mode control block
// Assumes: Nothing beyond the header of constants
// Notes: Types only
package pmc_pkg;

  typedef enum logic [2:0] {
    PMC_ST_IDLE = 3'b000,
    PMC_ST_ADDR = 3'b001,
    PMC_ST_ACK_ADDR = 3'b010,
    PMC_ST_WRITE = 3'b011,
    PMC_ST_ACK_WR = 3'b100,
    PMC_ST_READ = 3'b101,
    PMC_ST_RACK = 3'b110,
    PMC_ST_RLOAD = 3'b111
  } pmc_serial_state_type;

  typedef enum logic [1:0] {
    PMC_MODE_DIRECT = 2'b00,
    PMC_MODE_TABLE = 2'b01,
    PMC_MODE_TABLE_OFFSET = 2'b10
  } pmc_mode_type;

endpackage : pmc_pkg

// File: rtl/pmc_regs.svh
// Purpose: Offsets, field positions, reset values and constants of the pot mode control block
// Assumes: Byte-wide registers reached over the two-wire serial port
// Notes: Definitions only
`ifndef PMC_REGS_SVH
`define PMC_REGS_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define PMC_OFF_WIPER_IVR 8'h00
`define PMC_OFF_SHADOW_CTRL 8'h02
`define PMC_OFF_MODE_SEL 8'h03
`define PMC_OFF_TABLE_INDEX 8'h08
`define PMC_OFF_WIPER 8'h09
`define PMC_OFF_UPD_STBY 8'h0A

// ----------------------------------------------------------------------
// Field positions and masks
// ----------------------------------------------------------------------
`define PMC_BIT_SHADOW_BYPASS 7
`define PMC_BIT_TABLE_DRIVE 0
`define PMC_BIT_OFFSET_SUM 1
`define PMC_BIT_AUTOLOAD_DIS 2
`define PMC_BIT_INDEX_DIS 1
`define PMC_BIT_STANDBY 0
`define PMC_MASK_SHADOW_CTRL 8'h80
`define PMC_MASK_MODE_SEL 8'h03
`define PMC_MASK_UPD_STBY 8'h07

// ----------------------------------------------------------------------
// Reset values and limits
// ----------------------------------------------------------------------
`define PMC_RST_CTRL 8'h00
`define PMC_RST_WIPER 7'h00
`define PMC_WIPER_MAX 9'h07F
`define PMC_PAGE_MASK 8'hF8
`define PMC_PAGE_STEP 3'h1
`define PMC_BYTE_BITS 4'h8
`define PMC_BYTE_LAST 4'h7
// Upper five slave address bits; value arbitrary
`define PMC_SLAVE_HI 5'h0A

`endif

// File: rtl/pmc_serial_slave.sv
// Purpose: Two-wire serial slave byte engine for the pot mode control block
// Assumes: Clock far faster than the bus clock pin
// Notes: Open-drain data pin, driven low only
`include "pmc_regs.svh"

module pmc_serial_slave (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic scl_pin,
  input wire logic sda_pin,
  input wire logic [6:0] dev_addr,
  output logic sda_out,
  output logic sda_oe,
  output logic start_pulse,
  output logic stop_pulse,
  output logic wr_valid,
  output logic [7:0] wr_data,
  output logic rd_req,
  input wire logic [7:0] rd_data
);

  // ----------------------------------------------------------------------
  // Pin synchronisers, third stage only for edge detection
  // ----------------------------------------------------------------------
  logic [2:0] scl_q;
  logic [2:0] sda_q;
  pmc_pkg::pmc_serial_state_type state_q, state_d;
  logic [3:0] cnt_q, cnt_d;
  logic [7:0] sr_q, sr_d;
  logic rw_q, rw_d;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      scl_q <= 3'h7;
      sda_q <= 3'h7;
    end else if (ce) begin
      scl_q <= {scl_q[1:0], scl_pin};
      sda_q <= {sda_q[1:0], sda_pin};
    end
  end

  wire scl_rise = scl_q[1] & ~scl_q[2];
  wire scl_fall = ~scl_q[1] & scl_q[2];
  wire scl_high = scl_q[1] & scl_q[2];
  wire start_det = scl_high & ~sda_q[1] & sda_q[2];
  wire stop_det = scl_high & sda_q[1] & ~sda_q[2];
  wire byte_done = scl_fall && (cnt_q == `PMC_BYTE_BITS);
  wire [7:0] shift_in = {sr_q[6:0], sda_q[1]};
  wire addr_match = (sr_q[7:1] == dev_addr);

  // ----------------------------------------------------------------------
  // Byte sequencing
  // ----------------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    sr_d = sr_q;
    rw_d = rw_q;
    wr_valid = 1'b0;
    rd_req = 1'b0;
    if (start_det) begin
      state_d = pmc_pkg::PMC_ST_ADDR;
      cnt_d = 4'h0;
    end else if (stop_det) begin
      state_d = pmc_pkg::PMC_ST_IDLE;
    end else begin
      unique case (state_q)
        pmc_pkg::PMC_ST_IDLE: begin
        end
        pmc_pkg::PMC_ST_ADDR, pmc_pkg::PMC_ST_WRITE: begin
          if (scl_rise) begin
            sr_d = shift_in;
            cnt_d = cnt_q + 4'h1;
          end else if (byte_done && state_q == pmc_pkg::PMC_ST_WRITE) begin
            wr_valid = 1'b1;
            state_d = pmc_pkg::PMC_ST_ACK_WR;
          end else if (byte_done && addr_match) begin
            // Seven address bits then direction bit
            rw_d = sr_q[0];
            rd_req = sr_q[0];
            state_d = pmc_pkg::PMC_ST_ACK_ADDR;
          end else if (byte_done) begin
            // Foreign address: silent until next start
            state_d = pmc_pkg::PMC_ST_IDLE;
          end
        end
        pmc_pkg::PMC_ST_ACK_ADDR: begin
          if (scl_fall) begin
            cnt_d = 4'h0;
            sr_d = rw_q ? rd_data : sr_q;
            state_d = rw_q ? pmc_pkg::PMC_ST_READ : pmc_pkg::PMC_ST_WRITE;
          end
        end
        pmc_pkg::PMC_ST_ACK_WR: begin
          if (scl_fall) begin
            cnt_d = 4'h0;
            state_d = pmc_pkg::PMC_ST_WRITE;
          end
        end
        pmc_pkg::PMC_ST_READ: begin
          if (scl_fall && cnt_q == `PMC_BYTE_LAST) begin
            state_d = pmc_pkg::PMC_ST_RACK;
          end else if (scl_fall) begin
            sr_d = {sr_q[6:0], 1'b0};
            cnt_d = cnt_q + 4'h1;
          end
        end
        pmc_pkg::PMC_ST_RACK: begin
          if (scl_rise && sda_q[1]) begin
            state_d = pmc_pkg::PMC_ST_IDLE;
          end else if (scl_rise) begin
            rd_req = 1'b1;
            state_d = pmc_pkg::PMC_ST_RLOAD;
          end
        end
        pmc_pkg::PMC_ST_RLOAD: begin
          if (scl_fall) begin
            cnt_d = 4'h0;
            sr_d = rd_data;
            state_d = pmc_pkg::PMC_ST_READ;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state_q <= pmc_pkg::PMC_ST_IDLE;
      cnt_q <= 4'h0;
      sr_q <= 8'h00;
      rw_q <= 1'b0;
    end else if (ce) begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      sr_q <= sr_d;
      rw_q <= rw_d;
    end
  end

  assign start_pulse = start_det & ce;
  assign stop_pulse = stop_det & ce;
  assign wr_data = sr_q;
  assign sda_out = 1'b0;
  assign sda_oe = (state_q == pmc_pkg::PMC_ST_ACK_ADDR) || (state_q == pmc_pkg::PMC_ST_ACK_WR) ||
                  (state_q == pmc_pkg::PMC_ST_READ && !sr_q[7]);

endmodule : pmc_serial_slave

// File: rtl/pmc_top.sv
// Purpose: Mode and control registers of a temperature-compensated digital pot
// Assumes: Converter, lookup table and nonvolatile cells sit outside on this clock
// Notes: Registers reached only over the two-wire serial pins
`include "pmc_regs.svh"

module pmc_top #(
  parameter int INDEX_W = 6,
  parameter int TABLE_DEPTH = 36,
  parameter logic [4:0] SLAVE_HI = `PMC_SLAVE_HI
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic scl_pin,
  input wire logic sda_pin,
  output logic sda_out,
  output logic sda_oe,
  input wire logic addr_select_pin_lo,
  input wire logic addr_select_pin_hi,
  input wire logic conv_done,
  input wire logic [INDEX_W-1:0] conv_index,
  output logic [INDEX_W-1:0] table_index,
  input wire logic [7:0] table_output_value,
  output logic sensor_enable,
  output logic low_power,
  output logic operating,
  output logic [6:0] wiper_position,
  input wire logic [7:0] initial_value_stored,
  input wire logic [7:0] mode_stored,
  output logic nv_write,
  output logic nv_write_initial,
  output logic nv_write_mode,
  output logic [7:0] nv_initial_data,
  output logic [7:0] nv_mode_data
);

  // ----------------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------------
  if (INDEX_W < 1 || INDEX_W > 8 || TABLE_DEPTH > (1 << INDEX_W)) begin : g_bad_index
    $error("pmc_top: table index width cannot cover table depth");
  end

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  function automatic logic [6:0] pmc_offset_sum(input logic [7:0] base, input logic [7:0] delta);
    logic [8:0] sum;
    sum = {1'b0, base} + {delta[7], delta};
    if (sum[8] && delta[7]) begin
      pmc_offset_sum = 7'h00;
    end else if (sum > `PMC_WIPER_MAX) begin
      pmc_offset_sum = 7'h7F;
    end else begin
      pmc_offset_sum = sum[6:0];
    end
  endfunction : pmc_offset_sum

  function automatic logic [7:0] pmc_page_next(input logic [7:0] ptr);
    // Writes wrap inside the current eight-byte page
    pmc_page_next = (ptr & `PMC_PAGE_MASK) | {5'h00, ptr[2:0] + `PMC_PAGE_STEP};
  endfunction : pmc_page_next

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  logic [3:0] strap_q;
  logic init_q;
  logic [7:0] shadow_ctrl_q;
  logic [7:0] mode_sel_q;
  logic [7:0] upd_stby_q;
  logic [7:0] ivr_q;
  logic [6:0] wiper_q, wiper_d;
  logic [7:0] index_q;
  logic [7:0] ptr_q;
  logic have_ptr_q;
  logic [7:0] rd_data_q;
  logic pend_ivr_q;
  logic pend_mode_q;
  logic nv_write_q;
  logic nv_wr_ivr_q;
  logic nv_wr_mode_q;
  logic wake_wait_q;
  logic apply_q;

  logic start_pulse;
  logic stop_pulse;
  logic wr_valid;
  logic [7:0] wr_data;
  logic rd_req;

  // ----------------------------------------------------------------------
  // Serial port
  // ----------------------------------------------------------------------
  // Straps are static, but still pass two flops before use
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      strap_q <= 4'h0;
    end else if (ce) begin
      strap_q <= {strap_q[1:0], addr_select_pin_hi, addr_select_pin_lo};
    end
  end

  wire [6:0] dev_addr = {SLAVE_HI, strap_q[3], strap_q[2]};

  pmc_serial_slave u_slave (
    .clk(clk),
    .rst_b(rst_b),
    .ce(ce),
    .scl_pin(scl_pin),
    .sda_pin(sda_pin),
    .dev_addr(dev_addr),
    .sda_out(sda_out),
    .sda_oe(sda_oe),
    .start_pulse(start_pulse),
    .stop_pulse(stop_pulse),
    .wr_valid(wr_valid),
    .wr_data(wr_data),
    .rd_req(rd_req),
    .rd_data(rd_data_q)
  );

  // ----------------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------------
  wire bypass = shadow_ctrl_q[`PMC_BIT_SHADOW_BYPASS];
  wire table_drive = mode_sel_q[`PMC_BIT_TABLE_DRIVE];
  wire offset_sum = table_drive & mode_sel_q[`PMC_BIT_OFFSET_SUM];
  wire autoload_dis = upd_stby_q[`PMC_BIT_AUTOLOAD_DIS];
  wire index_dis = upd_stby_q[`PMC_BIT_INDEX_DIS];
  wire standby = upd_stby_q[`PMC_BIT_STANDBY];
  wire wr_now = wr_valid & have_ptr_q;
  wire hit_ivr = wr_now && ptr_q == `PMC_OFF_WIPER_IVR;
  wire hit_shadow = wr_now && ptr_q == `PMC_OFF_SHADOW_CTRL;
  wire hit_mode = wr_now && ptr_q == `PMC_OFF_MODE_SEL;
  wire hit_index = wr_now && ptr_q == `PMC_OFF_TABLE_INDEX && table_drive && index_dis;
  wire hit_wiper = wr_now && ptr_q == `PMC_OFF_WIPER && table_drive && autoload_dis;
  wire hit_upd = wr_now && ptr_q == `PMC_OFF_UPD_STBY;
  // Conversions are ignored entirely in standby
  wire conv_ok = conv_done & ~standby & init_q;
  wire auto_load = apply_q & table_drive & ~autoload_dis & ~standby;

  pmc_pkg::pmc_mode_type mode;
  assign mode = !table_drive ? pmc_pkg::PMC_MODE_DIRECT :
                offset_sum ? pmc_pkg::PMC_MODE_TABLE_OFFSET : pmc_pkg::PMC_MODE_TABLE;

  wire [7:0] rd_mux =
    (ptr_q == `PMC_OFF_WIPER_IVR) ? (table_drive ? ivr_q : {1'b0, wiper_q}) :
    (ptr_q == `PMC_OFF_SHADOW_CTRL) ? shadow_ctrl_q :
    (ptr_q == `PMC_OFF_MODE_SEL) ? mode_sel_q :
    (ptr_q == `PMC_OFF_TABLE_INDEX) ? index_q :
    (ptr_q == `PMC_OFF_WIPER) ? {1'b0, wiper_q} :
    (ptr_q == `PMC_OFF_UPD_STBY) ? upd_stby_q : 8'h00;

  // ----------------------------------------------------------------------
  // Pointer, read data and power-up recall
  // ----------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ptr_q <= 8'h00;
      have_ptr_q <= 1'b0;
      rd_data_q <= 8'h00;
    end else if (ce) begin
      if (start_pulse) begin
        have_ptr_q <= 1'b0;
      end else if (wr_valid && !have_ptr_q) begin
        ptr_q <= wr_data;
        have_ptr_q <= 1'b1;
      end else if (wr_valid) begin
        ptr_q <= pmc_page_next(ptr_q);
      end else if (rd_req) begin
        rd_data_q <= rd_mux;
        ptr_q <= ptr_q + 8'h01;
      end
    end
  end

  // Stored values are caught by a clocked load after reset release
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      init_q <= 1'b0;
      ivr_q <= `PMC_RST_CTRL;
      mode_sel_q <= `PMC_RST_CTRL;
    end else if (ce) begin
      init_q <= 1'b1;
      if (!init_q) begin
        ivr_q <= initial_value_stored;
        mode_sel_q <= mode_stored & `PMC_MASK_MODE_SEL;
      end else begin
        if (hit_ivr) begin
          ivr_q <= wr_data;
        end
        if (hit_mode) begin
          mode_sel_q <= wr_data & `PMC_MASK_MODE_SEL;
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // Volatile control registers
  // ----------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      shadow_ctrl_q <= `PMC_RST_CTRL;
      upd_stby_q <= `PMC_RST_CTRL;
    end else if (ce) begin
      if (hit_shadow) begin
        shadow_ctrl_q <= wr_data & `PMC_MASK_SHADOW_CTRL;
      end
      if (hit_upd) begin
        upd_stby_q <= wr_data & `PMC_MASK_UPD_STBY;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Nonvolatile commit, held back until the stop condition
  // ----------------------------------------------------------------------
  // A repeated start drops the pending commit, so the wiper moves without wear
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      pend_ivr_q <= 1'b0;
      pend_mode_q <= 1'b0;
      nv_write_q <= 1'b0;
      nv_wr_ivr_q <= 1'b0;
      nv_wr_mode_q <= 1'b0;
    end else if (ce) begin
      nv_write_q <= stop_pulse & (pend_ivr_q | pend_mode_q);
      if (stop_pulse) begin
        nv_wr_ivr_q <= pend_ivr_q;
        nv_wr_mode_q <= pend_mode_q;
      end
      if (start_pulse || stop_pulse) begin
        pend_ivr_q <= 1'b0;
        pend_mode_q <= 1'b0;
      end else begin
        pend_ivr_q <= pend_ivr_q | (hit_ivr & ~bypass);
        pend_mode_q <= pend_mode_q | (hit_mode & ~bypass);
      end
    end
  end

  // ----------------------------------------------------------------------
  // Temperature-driven index and wiper
  // ----------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      index_q <= 8'h00;
      apply_q <= 1'b0;
      wake_wait_q <= 1'b0;
    end else if (ce) begin
      // Index settles one cycle before the wiper samples the table
      apply_q <= conv_ok & table_drive;
      if (hit_index) begin
        index_q <= wr_data;
      end else if (conv_ok && table_drive && !index_dis) begin
        index_q <= 8'(conv_index);
      end
      if (standby) begin
        wake_wait_q <= 1'b1;
      end else if (conv_done) begin
        wake_wait_q <= 1'b0;
      end
    end
  end

  always_comb begin
    wiper_d = wiper_q;
    if (!init_q) begin
      wiper_d = initial_value_stored[6:0];
    end else if (hit_ivr && mode == pmc_pkg::PMC_MODE_DIRECT) begin
      wiper_d = wr_data[6:0];
    end else if (hit_wiper) begin
      wiper_d = wr_data[6:0];
    end else if (auto_load && mode == pmc_pkg::PMC_MODE_TABLE_OFFSET) begin
      wiper_d = pmc_offset_sum(ivr_q, table_output_value);
    end else if (auto_load) begin
      wiper_d = table_output_value[6:0];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      wiper_q <= `PMC_RST_WIPER;
    end else if (ce) begin
      wiper_q <= wiper_d;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign table_index = index_q[INDEX_W-1:0];
  assign sensor_enable = ~standby;
  assign low_power = standby;
  assign operating = ~standby & ~wake_wait_q & init_q;
  assign wiper_position = wiper_q;
  assign nv_write = nv_write_q;
  assign nv_write_initial = nv_wr_ivr_q;
  assign nv_write_mode = nv_wr_mode_q;
  assign nv_initial_data = ivr_q;
  assign nv_mode_data = mode_sel_q;

endmodule : pmc_top

// File: sim/pmc_bus_master.sv
// Purpose: Two-wire bus master model
// Assumes: Pull-up on the data line
// Notes: Bit time 12 clk, moves at falling clk
module pmc_bus_master (
  input wire logic clk,
  output logic scl,
  output logic sda_low,
  input wire logic sda
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic w(input int n);
    repeat (n) @(negedge clk);
  endtask : w
  // ----
  // Bit and frame tasks
  // ----
  // Data moves only while the clock line is low
  task automatic bit_io(input logic b, output logic r);
    sda_low = ~b;
    w(5);
    scl = 1'b1;
    w(5);
    r = sda;
    scl = 1'b0;
    w(2);
  endtask : bit_io
  task automatic start;
    sda_low = 1'b0;
    w(5);
    scl = 1'b1;
    w(5);
    sda_low = 1'b1;
    w(5);
    scl = 1'b0;
    w(2);
  endtask : start
  task automatic stop;
    sda_low = 1'b1;
    w(5);
    scl = 1'b1;
    w(5);
    sda_low = 1'b0;
    w(10);
  endtask : stop
  // Last bit sent as 1: releases for the slave or gives the closing no-ack
  task automatic byte_io(input logic [7:0] d, output logic [7:0] q, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r);
      q[i] = r;
    end
    bit_io(1'b1, r);
    ack = ~r;
  endtask : byte_io
  task automatic xfer(input logic [6:0] dev, input logic [7:0] p, input logic [7:0] d, input logic rd,
                      output logic [7:0] q, output logic ack);
    logic a;
    start;
    byte_io({dev, 1'b0}, q, ack);
    byte_io(p, q, a);
    if (rd) begin
      start;
      byte_io({dev, 1'b1}, q, a);
      byte_io(8'hFF, q, a);
    end else begin
      byte_io(d, q, a);
    end
    stop;
  endtask : xfer
endmodule : pmc_bus_master

// File: sim/pmc_top_checker.sv
// Purpose: Port checks of the pot mode control block
// Assumes: Single clock, synchronous active-low reset
// Notes: Attached by bind below
module pmc_top_checker #(
  parameter int INDEX_W = 6
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic scl_pin,
  input wire logic sda_pin,
  input wire logic sda_oe,
  input wire logic conv_done,
  input wire logic [INDEX_W-1:0] conv_index,
  input wire logic [INDEX_W-1:0] table_index,
  input wire logic low_power,
  input wire logic sensor_enable,
  input wire logic operating,
  input wire logic [6:0] wiper_position,
  input wire logic [7:0] initial_value_stored,
  input wire logic nv_write
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  // ----
  // Checks
  // ----
  a_reset_clear_state: assert property (
    $rose(rst_b) |-> wiper_position == 7'h00 && !nv_write && !operating && !sda_oe)
    else $error("state not cleared by reset");
  a_init_wiper_load: assert property (
    $rose(rst_b) && ce |=> wiper_position == initial_value_stored[6:0])
    else $error("wiper not loaded from stored value");
  a_stby_sensor_off: assert property (
    low_power |-> !sensor_enable && !operating)
    else $error("sensing active in standby");
  a_stby_hold_wiper: assert property (
    low_power && conv_done |=> $stable(table_index) ##1 $stable(wiper_position))
    else $error("standby state moved");
  a_index_from_conv: assert property (
    $changed(table_index) && $past(conv_done) |-> table_index == $past(conv_index))
    else $error("index not from converter");
  a_resume_wait: assert property (
    $fell(low_power) |-> !operating)
    else $error("operating before conversion");
  a_resume_on_conv: assert property (
    !low_power && !operating && conv_done && ce && $past(rst_b) |=> operating)
    else $error("operating not resumed");
  a_nv_after_stop: assert property (
    nv_write |-> scl_pin && sda_pin ##1 !nv_write)
    else $error("commit outside stop");
endmodule : pmc_top_checker

bind pmc_top pmc_top_checker #(.INDEX_W(INDEX_W)) i_chk (.clk, .rst_b, .ce, .scl_pin, .sda_pin, .sda_oe,
  .conv_done, .conv_index, .table_index, .low_power, .sensor_enable, .operating, .wiper_position,
  .initial_value_stored, .nv_write);

// File: sim/pmc_top_test.sv
// Purpose: Self-checking bench of the pot mode control block
// Assumes: Straps give slave address 29h
// Notes: Converter and table driven by the bench
module pmc_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [6:0] DEV = 7'h29;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic conv_done = 1'b0;
  logic [5:0] conv_index = 6'h00;
  logic [7:0] tbl_val = 8'h00;
  logic a_hi = 1'b0;
  logic scl, m_low, sda_out, sda_oe, low_power, sensor_enable, operating, nv_write, nv_wi, nv_wm, ack;
  logic [5:0] table_index;
  logic [6:0] wiper;
  logic [7:0] nv_id, nv_md, q;
  // Offset, write data, expected read back
  logic [23:0] rows [7] = '{24'h02FF80, 24'h020000, 24'h0AF800, 24'h03FE02, 24'h030101, 24'h083F00,
    24'h097F35};
  int error_cnt = 0;
  int samples_checked = 0;
  int nv_cnt = 0;
  wire sda = ~m_low & (sda_oe ? sda_out : 1'b1);
  always #4 clk = ~clk;
  always @(posedge clk) if (nv_write === 1'b1) nv_cnt++;
  pmc_bus_master i_master (.clk, .scl, .sda_low(m_low), .sda);
  pmc_top i_dut (.clk, .rst_b, .ce(1'b1), .scl_pin(scl), .sda_pin(sda), .sda_out, .sda_oe,
    .addr_select_pin_lo(1'b1), .addr_select_pin_hi(a_hi), .conv_done, .conv_index, .table_index,
    .table_output_value(tbl_val), .sensor_enable, .low_power, .operating, .wiper_position(wiper),
    .initial_value_stored(8'h35), .mode_stored(8'hFD), .nv_write, .nv_write_initial(nv_wi),
    .nv_write_mode(nv_wm), .nv_initial_data(nv_id), .nv_mode_data(nv_md));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] p, input logic [7:0] d);
    i_master.xfer(DEV, p, d, 1'b0, q, ack);
  endtask : wr
  task automatic rd(input logic [7:0] p, input logic [7:0] e);
    i_master.xfer(DEV, p, 8'h00, 1'b1, q, ack);
    chk(q, e);
  endtask : rd
  // Pulse lasts one clk; index then wiper settle two clk later
  task automatic conv(input logic [5:0] ix, input logic [7:0] tv);
    conv_index = ix;
    tbl_val = tv;
    conv_done = 1'b1;
    @(negedge clk);
    conv_done = 1'b0;
    repeat (4) @(negedge clk);
  endtask : conv
  task automatic finish_test;
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : finish_test
  initial begin
    repeat (100000) @(posedge clk);
    $display("mismatch %0t timeout", $time);
    error_cnt++;
    finish_test;
  end
  // ----
  // Main sequence
  // ----
  initial begin
    repeat (20) @(negedge clk);
    rst_b = 1'b1;
    repeat (4) @(negedge clk);
    chk({1'b0, wiper}, 8'h35);
    rd(8'h03, 8'h01);
    rd(8'h02, 8'h00);
    rd(8'h0A, 8'h00);
    i_master.xfer(7'h28, 8'h02, 8'h80, 1'b0, q, ack);
    chk({7'h00, ack}, 8'h00);
    foreach (rows[i]) begin
      wr(rows[i][23:16], rows[i][15:8]);
      rd(rows[i][23:16], rows[i][7:0]);
    end
    chk({7'h00, ack}, 8'h01);
    conv(6'h05, 8'h92);
    chk({2'b00, table_index}, 8'h05);
    chk({1'b0, wiper}, 8'h12);
    wr(8'h03, 8'h03);
    conv(6'h06, 8'hFE);
    chk({1'b0, wiper}, 8'h33);
    wr(8'h0A, 8'h04);
    conv(6'h07, 8'h01);
    chk({1'b0, wiper}, 8'h33);
    wr(8'h09, 8'h22);
    chk({1'b0, wiper}, 8'h22);
    wr(8'h0A, 8'h02);
    conv(6'h09, 8'h00);
    chk({2'b00, table_index}, 8'h07);
    chk({1'b0, wiper}, 8'h35);
    wr(8'h08, 8'h0B);
    chk({2'b00, table_index}, 8'h0B);
    wr(8'h0A, 8'h01);
    chk({6'h00, low_power, sensor_enable}, 8'h02);
    conv(6'h0C, 8'h10);
    chk({1'b0, wiper}, 8'h35);
    chk({2'b00, table_index}, 8'h0B);
    rd(8'h0A, 8'h01);
    wr(8'h0A, 8'h00);
    chk({7'h00, operating}, 8'h00);
    conv(6'h0D, 8'h02);
    chk({7'h00, operating}, 8'h01);
    chk({1'b0, wiper}, 8'h37);
    wr(8'h02, 8'h80);
    nv_cnt = 0;
    wr(8'h00, 8'h44);
    chk(nv_cnt[7:0], 8'h00);
    wr(8'h02, 8'h00);
    nv_cnt = 0;
    wr(8'h00, 8'h45);
    chk(nv_cnt[7:0], 8'h01);
    chk({nv_wi, nv_id[6:0]}, 8'hC5);
    // Offset bit alone must not leave direct mode
    wr(8'h03, 8'h02);
    chk({nv_wm, nv_wi, nv_md[5:0]}, 8'h82);
    conv(6'h10, 8'h7F);
    chk({1'b0, wiper}, 8'h37);
    wr(8'h00, 8'h21);
    chk({1'b0, wiper}, 8'h21);
    rd(8'h00, 8'h21);
    // Mid-run reset with the high strap moved: address becomes 2Bh
    wr(8'h0A, 8'h04);
    rst_b = 1'b0;
    a_hi = 1'b1;
    repeat (3) @(negedge clk);
    rst_b = 1'b1;
    repeat (4) @(negedge clk);
    chk({1'b0, wiper}, 8'h35);
    i_master.xfer(DEV, 8'h0A, 8'h00, 1'b1, q, ack);
    chk({7'h00, ack}, 8'h00);
    i_master.xfer(7'h2B, 8'h0A, 8'h00, 1'b1, q, ack);
    chk(q, 8'h00);
    chk({7'h00, ack}, 8'h01);
    i_master.xfer(7'h2B, 8'h03, 8'h00, 1'b1, q, ack);
    chk(q, 8'h01);
    finish_test;
  end
endmodule : pmc_top_test
